/* File: src/conv_ctrl.sv */
// Purpose: Control logic of a 10-bit successive-approximation converter
// Assumes: Registers reached over AXI4-Lite; the analog core delivers a result code
// Notes: Sampled code stands in for Vin*1024/Vref; all outputs are registered
// Notes on behaviour
// - Result is Vin*1024/Vref, 000 to 3ff
// - Result held in result pair after done
// - Two-bit field selects the reference source
// - Reference/channel changes wait until conversion ends
// - Alignment bit changes presentation immediately
// - Unused select bit four always reads zero
// - Four-bit field routes input channel
// - Enable on/off; clearing aborts running conversion
// - Start launches one, or first free-running
// - First conversion 25 cycles, later 13
// - Start reads one while busy; zero ignored
// - Auto trigger starts on selected rising edge
// - Done flag set at each conversion end
// - Interrupt needs flag, enable and global enable
// - Flag cleared by vector taken or write-one
// - Divider field: 2,2,4..128 system clocks
// - Free-running source never makes trigger event
// - Low byte read locks result until high read
// - Free running restarts while start stays high
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module conv_ctrl (
  input wire logic aclk, // System clock, 40 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [9:0] sample_code, // Analog core code for applied input
  input wire logic [7:0] trigger_lines, // Trigger flags, index by source code
  input wire logic global_irq_enable, // Global interrupt enable of the CPU
  input wire logic irq_taken, // Pulse: done vector is being taken
  output logic irq, // Conversion done interrupt request
  output logic [1:0] reference_select, // Applied reference
  output logic [3:0] input_channel_select, // Applied input channel
  output logic converter_on, // Analog core powered
  output logic sample_hold // High while a conversion runs
);

  // Divider length in system clocks for a field code
  // Codes zero and one both give two; above that each code doubles it
  function automatic logic [7:0] div_len(input logic [2:0] code);
    logic [7:0] v;
    v = 8'h01;
    if (code > 3'h1) begin
      v = 8'(8'h01 << code);
    end else begin
      v = 8'h02;
    end
    return v;
  endfunction : div_len

  // Aligned 16-bit result pair
  // Bits outside the ten result bits read zero in both alignments
  function automatic logic [15:0] align(input logic [9:0] r, input logic left);
    logic [15:0] v;
    v = left ? {r, 6'h00} : {6'h00, r};
    return v;
  endfunction : align

  // Idle lets the select register through; conv holds the applied copy
  typedef enum logic [1:0] {st_idle, st_conv} conv_state_t;

  // Whole block state; one process fills the copy, one registers it
  // Readies are kept as flops so every port leaves a register
  typedef struct packed {
    logic awready; // Write address ready, registered
    logic wready; // Write data ready, registered
    logic arready; // Read address ready, registered
    logic awdone; // Write address captured
    logic wdone; // Write data captured
    logic [7:0] awaddr; // Captured write address
    logic [31:0] wdata; // Captured write data
    logic [3:0] wstrb; // Captured strobes
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] sel; // Software copy of input select
    logic [1:0] ref_live; // Applied reference
    logic [3:0] ch_live; // Applied channel
    logic enable;
    logic start;
    logic auto_trig;
    logic done;
    logic irq_en;
    logic [2:0] divider;
    logic [2:0] trig_src;
    logic trig_prev; // Previous trigger level for edge detect
    logic first_pending; // Next conversion is the long first one
    conv_state_t state;
    logic [7:0] pre_cnt; // Prescaler count in system clocks
    logic [4:0] cyc_cnt; // Converter clock cycles done
    logic [4:0] cyc_len; // Length of running conversion
    logic [9:0] result;
    logic locked; // Low byte read, high not yet
    logic irq;
  } state_t;

  state_t cur, nxt;
  logic trig_now;
  logic [15:0] pair;

  // Selected trigger level and presented result
  assign trig_now = trigger_lines[cur.trig_src];
  assign pair = align(cur.result, cur.sel[conv_ctrl_pkg::pos_left_align]);

  // Next-state logic: bus slave, conversion sequencer and flags
  always_comb begin
    logic wr_fire;
    logic start_req;
    logic conv_end;
    logic [7:0] wb;
    wr_fire = 1'b0;
    start_req = 1'b0;
    conv_end = 1'b0;
    wb = 8'h00;
    nxt = cur;

    // Write address and data taken independently
    if (s_axi_awvalid && !cur.awdone) begin
      nxt.awdone = 1'b1;
      nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !cur.wdone) begin
      nxt.wdone = 1'b1;
      nxt.wdata = s_axi_wdata;
      nxt.wstrb = s_axi_wstrb;
    end
    // A held response blocks the next write, so one write at most is in flight
    if (cur.bvalid && s_axi_bready) begin
      nxt.bvalid = 1'b0;
    end
    if (cur.awdone && cur.wdone && !cur.bvalid) begin
      wr_fire = cur.wstrb[0];
      wb = cur.wdata[7:0];
      nxt.awdone = 1'b0;
      nxt.wdone = 1'b0;
      nxt.bvalid = 1'b1;
      nxt.bresp = conv_ctrl_pkg::resp_okay;
      case (cur.awaddr)
        conv_ctrl_pkg::off_input_select: begin
          if (wr_fire) begin
            nxt.sel = wb;
            nxt.sel[conv_ctrl_pkg::pos_unused_bit] = 1'b0;
          end
        end
        conv_ctrl_pkg::off_control_status: begin
          if (wr_fire) begin
            // Whole-value writes only: writing a set flag back as one clears it
            nxt.enable = wb[conv_ctrl_pkg::pos_enable];
            nxt.auto_trig = wb[conv_ctrl_pkg::pos_auto_trigger];
            nxt.irq_en = wb[conv_ctrl_pkg::pos_irq_enable];
            nxt.divider = wb[conv_ctrl_pkg::pos_divider +: 3];
            if (!cur.enable && wb[conv_ctrl_pkg::pos_enable]) begin
              nxt.first_pending = 1'b1;
            end
            // Writing one with enable set starts; zero has no effect
            if (wb[conv_ctrl_pkg::pos_start] && wb[conv_ctrl_pkg::pos_enable]) begin
              start_req = 1'b1;
            end
          end
        end
        conv_ctrl_pkg::off_trigger_config: begin
          if (wr_fire) begin
            nxt.trig_src = wb[2:0];
          end
        end
        conv_ctrl_pkg::off_result_low, conv_ctrl_pkg::off_result_high: begin
          nxt.bresp = conv_ctrl_pkg::resp_okay; // Read-only: write ignored
        end
        default: begin
          nxt.bresp = conv_ctrl_pkg::resp_slverr; // Unmapped
        end
      endcase
    end

    // Read channel; answers one cycle after address taken
    if (cur.rvalid && s_axi_rready) begin
      nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !cur.rvalid) begin
      nxt.rvalid = 1'b1;
      nxt.rresp = conv_ctrl_pkg::resp_okay;
      // Cleared first so upper bytes and refused reads return zero
      nxt.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        conv_ctrl_pkg::off_input_select: begin
          nxt.rdata[7:0] = cur.sel;
        end
        conv_ctrl_pkg::off_control_status: begin
          nxt.rdata[7:0] = {cur.enable, cur.start, cur.auto_trig, cur.done, cur.irq_en, cur.divider};
        end
        conv_ctrl_pkg::off_trigger_config: begin
          nxt.rdata[2:0] = cur.trig_src;
        end
        conv_ctrl_pkg::off_result_low: begin
          // Low byte read freezes the result until the high byte is read
          nxt.rdata[7:0] = pair[7:0];
          nxt.locked = 1'b1;
        end
        conv_ctrl_pkg::off_result_high: begin
          nxt.rdata[7:0] = pair[15:8];
          nxt.locked = 1'b0;
        end
        default: begin
          nxt.rresp = conv_ctrl_pkg::resp_slverr;
        end
      endcase
    end

    // Auto trigger on rising edge of selected source; free running gives none
    // Switching from a low source to one that is already high counts as an edge
    nxt.trig_prev = trig_now;
    if (cur.enable && cur.auto_trig && cur.trig_src != conv_ctrl_pkg::trig_free_running
        && trig_now && !cur.trig_prev) begin
      start_req = 1'b1;
    end

    // Sequencer: count converter clock cycles through the prescaler
    // The prescaler restarts with each conversion so its length is exact
    case (cur.state)
      st_idle: begin
        nxt.ref_live = cur.sel[conv_ctrl_pkg::pos_reference_select +: 2];
        nxt.ch_live = cur.sel[conv_ctrl_pkg::pos_channel +: 4];
        if (start_req) begin
          nxt.state = st_conv;
          nxt.start = 1'b1;
          nxt.pre_cnt = 8'h00;
          nxt.cyc_cnt = 5'h00;
          nxt.cyc_len = (nxt.first_pending) ? conv_ctrl_pkg::first_conv_cycles
                                            : conv_ctrl_pkg::normal_conv_cycles;
          nxt.first_pending = 1'b0;
        end
      end
      st_conv: begin
        // Channel and reference stay frozen until the last cycle
        if (cur.pre_cnt == div_len(cur.divider) - 8'h01) begin
          nxt.pre_cnt = 8'h00;
          nxt.cyc_cnt = cur.cyc_cnt + 5'h01;
          if (cur.cyc_cnt == cur.cyc_len - 5'h01) begin
            conv_end = 1'b1;
          end
        end else begin
          nxt.pre_cnt = cur.pre_cnt + 8'h01;
        end
        if (conv_end) begin
          // A locked pair keeps the old result, but the flag still sets
          if (!cur.locked) begin
            nxt.result = sample_code;
          end
          nxt.done = 1'b1;
          nxt.ref_live = cur.sel[conv_ctrl_pkg::pos_reference_select +: 2];
          nxt.ch_live = cur.sel[conv_ctrl_pkg::pos_channel +: 4];
          if (cur.auto_trig && cur.trig_src == conv_ctrl_pkg::trig_free_running) begin
            nxt.cyc_cnt = 5'h00;
            nxt.cyc_len = conv_ctrl_pkg::normal_conv_cycles;
          end else begin
            nxt.state = st_idle;
            nxt.start = 1'b0;
          end
        end
      end
      default: begin
        nxt.state = st_idle;
      end
    endcase

    // Disable aborts any conversion
    // An abort leaves the flag and the old result untouched
    if (!nxt.enable) begin
      nxt.state = st_idle;
      nxt.start = 1'b0;
    end

    // Done flag: write-one or vector clears, a same-cycle set wins
    if ((wr_fire && cur.awaddr == conv_ctrl_pkg::off_control_status && wb[conv_ctrl_pkg::pos_done_flag])
        || irq_taken) begin
      nxt.done = conv_end;
    end

    // The request registers in the same cycle as the flag and never leads the enables
    nxt.irq = nxt.done && nxt.irq_en && global_irq_enable;

    // Readies are the registered inverse of the holding flags
    nxt.awready = !nxt.awdone;
    nxt.wready = !nxt.wdone;
    nxt.arready = !nxt.rvalid;
  end

  // State register with synchronous reset and clock enable
  // Enable low holds every bit, bus handshakes included
  // Limitation: the master must not run the bus while the enable is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
      cur.state <= st_idle;
      cur.awready <= 1'b1;
      cur.wready <= 1'b1;
      cur.arready <= 1'b1;
      cur.sel <= conv_ctrl_pkg::reset_input_select;
      cur.trig_src <= conv_ctrl_pkg::reset_trigger_source;
    end else if (clk_en) begin
      cur <= nxt;
    end
  end

  // Outputs straight from state flip-flops
  assign s_axi_awready = cur.awready;
  assign s_axi_wready = cur.wready;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_arready = cur.arready;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;
  assign irq = cur.irq;
  assign reference_select = cur.ref_live;
  assign input_channel_select = cur.ch_live;
  assign converter_on = cur.enable;
  assign sample_hold = cur.start;

endmodule : conv_ctrl

/* File: src/conv_ctrl_pkg.sv */
// Purpose: Shared constants for the converter control block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: Offsets are byte addresses chosen for this block
package conv_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] off_input_select = 8'h00;
  localparam logic [7:0] off_control_status = 8'h04;
  localparam logic [7:0] off_trigger_config = 8'h08;
  localparam logic [7:0] off_result_low = 8'h0c;
  localparam logic [7:0] off_result_high = 8'h10;
  // Input select fields
  localparam int pos_reference_select = 6;
  localparam int pos_left_align = 5;
  localparam int pos_unused_bit = 4;
  localparam int pos_channel = 0;
  // Control status fields
  localparam int pos_enable = 7;
  localparam int pos_start = 6;
  localparam int pos_auto_trigger = 5;
  localparam int pos_done_flag = 4;
  localparam int pos_irq_enable = 3;
  localparam int pos_divider = 0;
  // Reset values
  localparam logic [7:0] reset_input_select = 8'h00;
  localparam logic [7:0] reset_control_status = 8'h00;
  localparam logic [2:0] reset_trigger_source = 3'h0;
  // Conversion lengths in converter clock cycles
  localparam logic [4:0] first_conv_cycles = 5'h19;
  localparam logic [4:0] normal_conv_cycles = 5'h0d;
  // Free running trigger code
  localparam logic [2:0] trig_free_running = 3'h0;
  // AXI responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : conv_ctrl_pkg

/* File: verif/analog_front.sv */
// Purpose: Far-side model of the analog core
// Assumes: Code names reference and channel
// Notes: Unpowered core gives a toggling code
`timescale 1ns/1ps
module analog_front (
  input wire logic aclk, // Clock
  input wire logic [1:0] reference_select, // Applied reference
  input wire logic [3:0] input_channel_select, // Applied channel
  input wire logic converter_on, // Core powered
  output logic [9:0] sample_code // Code to block
);
  logic [9:0] junk = 10'h2aa; // Never a stable value
  // Flip each cycle so a stale code cannot pass
  always_ff @(posedge aclk) junk <= ~junk;
  // Ground channel is code zero; others encode ref and channel
  always_comb begin
    if (!converter_on) sample_code = junk;
    else if (input_channel_select == 4'hf) sample_code = 10'h000;
    else sample_code = {reference_select, 4'h5, input_channel_select};
  end
endmodule : analog_front

/* File: verif/conv_ctrl_checker.sv */
// Purpose: Port assertions for conv_ctrl
// Assumes: Sees only top ports
// Notes: Bound below
`timescale 1ns/1ps
module conv_ctrl_checker (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic [7:0] s_axi_araddr, // Read addr
  input wire logic s_axi_arvalid, // Addr valid
  input wire logic s_axi_arready, // Addr ready
  input wire logic [31:0] s_axi_rdata, // Data
  input wire logic [1:0] s_axi_rresp, // Resp
  input wire logic s_axi_rvalid, // Data valid
  input wire logic global_irq_enable, // CPU enable
  input wire logic irq_taken, // Vector taken
  input wire logic irq, // Request
  input wire logic [3:0] input_channel_select, // Channel
  input wire logic converter_on, // Powered
  input wire logic sample_hold // Busy
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] rd_addr; // Read in flight
  // Keep the address so returned data can be judged
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
  end
  a_irq_needs_global: assert property (irq |-> $past(global_irq_enable))
    else $error("irq without global enable");
  a_unused_bit_zero: assert property (s_axi_rvalid && rd_addr == 8'h00 |-> !s_axi_rdata[4])
    else $error("unused select bit read one");
  logic [3:0] ch_prev; // Applied channel one cycle ago
  logic [7:0] busy_age; // Busy cycles since start or last channel move
  // Free running may move the channel, but only at a conversion end
  always_ff @(posedge aclk) begin
    ch_prev <= input_channel_select;
    if (!sample_hold || input_channel_select != ch_prev) busy_age <= 8'h00;
    else if (busy_age != 8'hff) busy_age <= busy_age + 8'h01;
  end
  a_chan_locked: assert property (sample_hold && $past(sample_hold)
    && $changed(input_channel_select) |-> busy_age >= 8'h19)
    else $error("channel moved mid conversion");
  a_conv_min_len: assert property ($rose(sample_hold) |-> (sample_hold || !converter_on)[*8])
    else $error("conversion too short");
  a_off_idle: assert property (!converter_on && !$past(converter_on) |-> !sample_hold)
    else $error("busy while off");
  a_irq_clear: assert property (irq_taken && !sample_hold |-> ##2 !irq)
    else $error("irq kept after vector");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_bad_addr_err: assert property (s_axi_rvalid && rd_addr > 8'h10 |-> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  c_conv: cover property ($rose(sample_hold));
  c_irq: cover property ($rose(irq));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : conv_ctrl_checker
bind conv_ctrl conv_ctrl_checker chk_i (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .global_irq_enable, .irq_taken, .irq, .input_channel_select,
  .converter_on, .sample_hold);

/* File: verif/tb_top.sv */
// Purpose: Self-checking bench for conv_ctrl
// Assumes: AXI4-Lite master tasks, analog_front far side
// Notes: Register rows, then conversions
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [31:0] q; logic [1:0] r;} row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic global_irq_enable, irq_taken, irq, converter_on, sample_hold;
  logic [7:0] s_axi_awaddr, s_axi_araddr, trigger_lines;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, hold_base;
  logic [31:0] hold_cnt = 32'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, reference_select, rr;
  logic [3:0] input_channel_select;
  logic [9:0] sample_code;
  int errors = 0;
  int samples_checked = 0;
  // Write, read back: reserved bits zero, results read-only, unmapped refused
  row_t rows [6] = '{'{8'h00, 8'h00, 32'h0, 2'h0}, '{8'h08, 8'h00, 32'h0, 2'h0},
    '{8'h0c, 8'hff, 32'h0, 2'h0}, '{8'h14, 8'hff, 32'h0, 2'h2},
    '{8'h00, 8'hff, 32'hef, 2'h0}, '{8'h08, 8'hff, 32'h07, 2'h0}};
  conv_ctrl uut (.aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_code,
    .trigger_lines, .global_irq_enable, .irq_taken, .irq, .reference_select, .input_channel_select,
    .converter_on, .sample_hold);
  analog_front model (.aclk, .reference_select, .input_channel_select, .converter_on, .sample_code);
  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Busy length counter, sampled mid-cycle to stay clear of edges
  always @(negedge aclk) hold_cnt <= hold_cnt + {31'h0, sample_hold};
  task automatic end_of_test;
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic hang;
    $display("ERROR %0t wait timed out", $time);
    errors++;
    end_of_test();
  endtask : hang
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One write; channels released as each is taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, b;
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      n++;
    end while (!b && n < 60);
    s_axi_bready <= 1'b0;
    if (!b) hang();
    @(posedge aclk);
  endtask : wr
  // One read into rd and rr
  task automatic rdx(input logic [7:0] a);
    logic ar, v;
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar = s_axi_arready;
      v = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      n++;
    end while (!v && n < 60);
    s_axi_rready <= 1'b0;
    if (!v) hang();
    @(posedge aclk);
  endtask : rdx
  task automatic rdc(input logic [7:0] a, input logic [31:0] q);
    rdx(a);
    chk(rd, q);
  endtask : rdc
  // Bounded wait for the busy level
  task automatic hw(input logic v);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (sample_hold !== v && n < 400);
    @(posedge aclk);
    if (sample_hold !== v) hang();
  endtask : hw
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, global_irq_enable} = '0;
    {irq_taken, trigger_lines, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].q);
      chk({30'h0, rr}, {30'h0, rows[i].r});
    end
    // Reset after nonzero writes
    do_reset();
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0);
    // First conversion: 25 clocks of 2
    wr(8'h00, 8'h43);
    hold_base = hold_cnt;
    wr(8'h04, 8'hc0);
    hw(1'b1);
    hw(1'b0);
    chk(hold_cnt - hold_base, 32'h32);
    // Second: 13 clocks of 8, channel change deferred
    hold_base = hold_cnt;
    wr(8'h04, 8'hc3);
    wr(8'h00, 8'h45);
    chk({28'h0, input_channel_select}, 32'h3);
    hw(1'b0);
    chk(hold_cnt - hold_base, 32'h68);
    chk({28'h0, input_channel_select}, 32'h5);
    rdc(8'h0c, 32'h53);
    rdc(8'h10, 32'h01);
    wr(8'h00, 8'h65);
    rdc(8'h10, 32'h54);
    rdc(8'h0c, 32'hc0);
    rdc(8'h04, 32'h93);
    // Interrupt gating and vector clear
    global_irq_enable <= 1'b1;
    wr(8'h04, 8'h8b);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    global_irq_enable <= 1'b1;
    irq_taken <= 1'b1;
    @(posedge aclk);
    irq_taken <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rdc(8'h04, 32'h8b);
    // Trigger edge, then switch to free running with flag set
    wr(8'h08, 8'h02);
    wr(8'h04, 8'ha3);
    trigger_lines <= 8'h04;
    hw(1'b1);
    hw(1'b0);
    trigger_lines <= 8'h01;
    wr(8'h08, 8'h00);
    chk({31'h0, sample_hold}, 32'h0);
    wr(8'h04, 8'h93);
    rdc(8'h04, 32'h83);
    rdc(8'h10, 32'h54);
    // Abort by disable
    wr(8'h04, 8'hc3);
    wr(8'h04, 8'h03);
    chk({31'h0, sample_hold}, 32'h0);
    rdc(8'h04, 32'h03);
    // Free running keeps converting
    wr(8'h04, 8'he0);
    repeat (80) @(posedge aclk);
    chk({31'h0, sample_hold}, 32'h1);
    rdc(8'h04, 32'hf0);
    rdc(8'h10, 32'h55);
    wr(8'h04, 8'h00);
    end_of_test();
  end
endmodule : tb_top
